// ---- core/stp_pkg.sv ----
`default_nettype none
package stp_pkg;
  // ----------------------------------------------------------------
  // Data widths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W   = 16;              // Audio sample width
  localparam int MIX_W      = SAMPLE_W + 2;    // Sum of three samples
  localparam int COEFF_W    = 16;              // Biquad coefficient width
  localparam int NUM_COEFF  = 16;              // 32 byte slots, 16 words
  localparam int FIFO_DEPTH = 16;              // Sample FIFO depth

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL    = 8'hE4;  // side_tone_control
  localparam logic [7:0] IDX_SRC     = 8'hE5;  // side_tone_source_select
  localparam logic [7:0] IDX_LEVEL   = 8'hE6;  // side_tone_level
  localparam logic [7:0] IDX_LMASK   = 8'hE8;  // left_stream_sources
  localparam logic [7:0] IDX_RMASK   = 8'hE9;  // right_stream_sources
  localparam logic [7:0] IDX_CDATA   = 8'hEA;  // coefficient_byte_value
  localparam logic [7:0] IDX_CINDEX  = 8'hEB;  // coefficient_byte_index
  localparam logic [7:0] IDX_FILT_ON = 8'hEC;  // Output filter enables

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT     = 7;          // Path on
  localparam int CTRL_MUTE_BIT   = 6;          // Path muted
  localparam int MASK_OWN_BIT    = 0;          // Same-side filter (left view)
  localparam int MASK_OPP_BIT    = 1;          // Opposite filter (left view)
  localparam int MASK_SIDE_BIT   = 2;          // Sidetone
  localparam int FILT_ON_L_BIT   = 0;          // left_out_filter_on
  localparam int FILT_ON_R_BIT   = 1;          // right_out_filter_on

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       RST_EN      = 1'h0;   // Path off
  localparam logic       RST_MUTE    = 1'h1;   // Muted
  localparam logic [1:0] RST_SRC     = 2'h0;   // Record channel 1 left
  localparam logic [4:0] RST_LEVEL   = 5'h1C;  // 0 dB
  localparam logic [2:0] RST_LMASK   = 3'h1;   // Left filter only
  localparam logic [2:0] RST_RMASK   = 3'h2;   // Right filter only
  localparam logic [7:0] RST_CDATA   = 8'h00;  // Data byte
  localparam logic [4:0] RST_CINDEX  = 5'h00;  // Byte index
  localparam logic [1:0] RST_FILT_ON = 2'h0;   // Filters off

  // ----------------------------------------------------------------
  // Gain scale in hundredths of a dB
  // ----------------------------------------------------------------
  localparam logic signed [15:0] GAIN_BASE_CDB = -16'sd4200; // Code 0
  localparam logic signed [15:0] GAIN_STEP_CDB = 16'sd150;   // Per code

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_REC1_L, SRC_REC1_R, SRC_REC2_L, SRC_REC2_R
  } stp_src_t;

  typedef struct packed {
    logic [3:0][SAMPLE_W-1:0] rec;             // Record channels by source code
    logic [SAMPLE_W-1:0]      filt_l;          // Output filter 1 left
    logic [SAMPLE_W-1:0]      filt_r;          // Output filter 1 right
  } stp_in_frame_t;

  typedef struct packed {
    logic [MIX_W-1:0]    left;                 // left_output_stream
    logic [MIX_W-1:0]    right;                // right_output_stream
    logic [SAMPLE_W-1:0] side;                 // Selected sidetone sample
  } stp_out_frame_t;
endpackage : stp_pkg
`default_nettype wire

// ---- core/stp_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module stp_fifo #(
  parameter int W     = 8,                     // Word width
  parameter int DEPTH = 16                     // Word count
) (
  input  wire logic         clk,               // Core clock
  input  wire logic         srst,              // Sync reset
  input  wire logic         in_valid,          // Write request
  output var  logic         in_ready,          // Room available
  input  wire logic [W-1:0] in_data,           // Write word
  output logic              out_valid,         // Word available
  input  wire logic         out_ready,         // Read accept
  output logic      [W-1:0] out_data           // Head word
);
  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [W-1:0]  mem [DEPTH];                  // Word storage
  logic [PW-1:0] wr_ptr_ff;                    // Write slot
  logic [PW-1:0] rd_ptr_ff;                    // Read slot
  logic [PW:0]   count_ff;                     // Words held
  logic [PW:0]   nxt_count;                    // Next word count
  logic          push;                         // Word enters
  logic          pop;                          // Word leaves

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];

  // Next occupancy
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  // Occupancy and registered room flag
  always_ff @(posedge clk) begin
    if (srst) begin
      count_ff <= '0;
      in_ready <= 1'b1;
    end else begin
      count_ff <= nxt_count;
      in_ready <= (nxt_count != (PW+1)'(DEPTH));
    end
  end

  // Pointers
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
    end
  end

  // Word write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
endmodule : stp_fifo
`default_nettype wire

// ---- core/stp_sidetone_ctrl.sv ----
// Contract
// - Control bit 7 enables path, reset off
// - Control bit 6 mutes, reset muted
// - Two-bit source picks record channel, reset 0
// - Gain code 0 is -42 dB, 1.5 dB steps
// - Left mask bits add filters and sidetone
// - Right mask same layout, reset 0x2
// - Opposite filter bit needs own filter enable
// - Eight-bit data byte for three-stage biquad
// - Even index low byte, odd high byte
// - Index write copies data byte into coefficient; here an even index only stages it, an odd index commits the word
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module stp_sidetone_ctrl
  import stp_pkg::*;
#(
  parameter int ADDR_W = 12,                   // APB address width
  parameter int DEPTH  = FIFO_DEPTH            // Sample FIFO depth
) (
  input  wire logic                clk,        // Core clock
  input  wire logic                srst,       // Sync reset
  input  wire logic                psel,       // APB select
  input  wire logic                penable,    // APB access phase
  input  wire logic                pwrite,     // APB write
  input  wire logic [ADDR_W-1:0]   paddr,      // APB byte address
  input  wire logic [31:0]         pwdata,     // APB write data
  output logic      [31:0]         prdata,     // APB read data
  output logic                     pready,     // APB ready
  output logic                     pslverr,    // APB error
  input  wire logic                in_valid,   // Sample frame valid
  output logic                     in_ready,   // Sample frame room
  input  wire stp_in_frame_t       in_frame,   // Sample frame
  output logic                     out_valid,  // Mixed frame valid
  input  wire logic                out_ready,  // Mixed frame accept
  output stp_out_frame_t           out_frame,  // Mixed frame
  output logic                     side_live,  // Path on and unmuted
  output logic signed [15:0]       gain_cdb,   // Gain in 0.01 dB
  output logic [NUM_COEFF-1:0][COEFF_W-1:0] coeff,     // Active coefficients
  output logic                     coeff_upd,  // Word committed pulse
  output logic [3:0]               coeff_upd_idx // Committed word slot
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Gain code to hundredths of a dB
  function automatic logic signed [15:0] code_to_cdb(input logic [4:0] code);
    code_to_cdb = GAIN_BASE_CDB + $signed({11'h000, code}) * GAIN_STEP_CDB;
  endfunction : code_to_cdb

  // One output stream sum; own, opposite and sidetone terms
  function automatic logic [MIX_W-1:0] mix(input logic [2:0] mask,
                                           input logic [SAMPLE_W-1:0] own,
                                           input logic [SAMPLE_W-1:0] opp,
                                           input logic [SAMPLE_W-1:0] side,
                                           input logic own_on);
    logic [MIX_W-1:0] acc;
    acc = '0;
    if (mask[MASK_OWN_BIT])           acc = acc + MIX_W'(own);
    if (mask[MASK_OPP_BIT] && own_on) acc = acc + MIX_W'(opp);
    if (mask[MASK_SIDE_BIT])          acc = acc + MIX_W'(side);
    mix = acc;
  endfunction : mix

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic           en_ff;                       // Path on
  logic           mute_ff;                     // Path muted
  stp_src_t       src_ff;                      // Sidetone source
  logic [4:0]     level_ff;                    // Gain code
  logic [2:0]     lmask_ff;                    // left_stream_source_mask
  logic [2:0]     rmask_ff;                    // right_stream_source_mask
  logic [7:0]     cdata_ff;                    // coeff_byte_value
  logic [4:0]     cindex_ff;                   // coeff_byte_index
  logic [1:0]     filt_on_ff;                  // Output filter enables
  logic [7:0]     low_stage [NUM_COEFF];       // Pending low bytes

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0]     idx;                         // Word index
  logic           mapped;                      // Index decodes
  logic           access;                      // Transfer completes
  logic           wr;                          // Mapped write completes
  logic [7:0]     rd_val;                      // Read mux value

  assign idx    = 8'(paddr[ADDR_W-1:2]);
  assign access = psel && penable && pready;
  assign wr     = access && pwrite && mapped;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    unique case (idx)
      IDX_CTRL:    rd_val = {en_ff, mute_ff, 6'h00};
      IDX_SRC:     rd_val = {6'h00, src_ff};
      IDX_LEVEL:   rd_val = {3'h0, level_ff};
      IDX_LMASK:   rd_val = {5'h00, lmask_ff};
      IDX_RMASK:   rd_val = {5'h00, rmask_ff};
      IDX_CDATA:   rd_val = cdata_ff;
      IDX_CINDEX:  rd_val = {3'h0, cindex_ff};
      IDX_FILT_ON: rd_val = {6'h00, filt_on_ff};
      default:     mapped = 1'b0;
    endcase
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        prdata <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h000000, rd_val};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Path control, source, gain, masks, filter enables
  always_ff @(posedge clk) begin
    if (srst) begin
      en_ff      <= RST_EN;
      mute_ff    <= RST_MUTE;
      src_ff     <= stp_src_t'(RST_SRC);
      level_ff   <= RST_LEVEL;
      lmask_ff   <= RST_LMASK;
      rmask_ff   <= RST_RMASK;
      filt_on_ff <= RST_FILT_ON;
    end else if (wr) begin
      unique case (idx)
        IDX_CTRL: begin
          en_ff   <= pwdata[CTRL_EN_BIT];
          mute_ff <= pwdata[CTRL_MUTE_BIT];
        end
        IDX_SRC:     src_ff     <= stp_src_t'(pwdata[1:0]);
        IDX_LEVEL:   level_ff   <= pwdata[4:0];
        IDX_LMASK:   lmask_ff   <= pwdata[2:0];
        IDX_RMASK:   rmask_ff   <= pwdata[2:0];
        IDX_FILT_ON: filt_on_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Status seen by the filter datapath
  always_ff @(posedge clk) begin
    if (srst) begin
      side_live <= 1'b0;
      gain_cdb  <= code_to_cdb(RST_LEVEL);
    end else begin
      side_live <= en_ff && !mute_ff;
      gain_cdb  <= code_to_cdb(level_ff);
    end
  end

  // ----------------------------------------------------------------
  // Coefficient loading
  // ----------------------------------------------------------------
  logic       idx_wr;                          // Index register written
  logic [4:0] new_index;                       // Byte slot written

  assign idx_wr    = wr && (idx == IDX_CINDEX);
  assign new_index = pwdata[4:0];

  // Data byte and byte index registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cdata_ff  <= RST_CDATA;
      cindex_ff <= RST_CINDEX;
    end else begin
      if (wr && idx == IDX_CDATA) cdata_ff <= pwdata[7:0];
      if (idx_wr)                 cindex_ff <= new_index;
    end
  end

  // Low byte waits; high byte commits the whole word
  always_ff @(posedge clk) begin
    if (srst) begin
      coeff         <= '0;
      coeff_upd     <= 1'b0;
      coeff_upd_idx <= 4'h0;
      for (int i = 0; i < NUM_COEFF; i++) low_stage[i] <= 8'h00;
    end else begin
      coeff_upd <= 1'b0;
      if (idx_wr) begin
        if (!new_index[0]) begin
          low_stage[new_index[4:1]] <= cdata_ff;
        end else begin
          coeff[new_index[4:1]] <= {cdata_ff, low_stage[new_index[4:1]]};
          coeff_upd             <= 1'b1;
          coeff_upd_idx         <= new_index[4:1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  stp_in_frame_t       head;                   // FIFO head frame
  logic                head_valid;             // FIFO head valid
  logic                pop;                    // Head consumed
  logic [SAMPLE_W-1:0] side_smp;               // Gated sidetone sample

  assign pop      = head_valid && (!out_valid || out_ready);
  assign side_smp = (en_ff && !mute_ff) ? head.rec[src_ff] : '0;

  stp_fifo #(
    .W     ($bits(stp_in_frame_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_frame),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head)
  );

  // Output frame register
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_frame <= '0;
    end else if (pop) begin
      out_valid       <= 1'b1;
      out_frame.side  <= side_smp;
      out_frame.left  <= mix(lmask_ff, head.filt_l, head.filt_r, side_smp,
                             filt_on_ff[FILT_ON_L_BIT]);
      out_frame.right <= mix({rmask_ff[2], rmask_ff[0], rmask_ff[1]},
                             head.filt_r, head.filt_l, side_smp,
                             filt_on_ff[FILT_ON_R_BIT]);
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_rst_path;
    $past(srst) |-> !en_ff && mute_ff && src_ff == SRC_REC1_L;
  endproperty
  a_rst_path: assert property (p_rst_path) else $error("path reset wrong");

  property p_en_write;
    wr && idx == IDX_CTRL |=> en_ff == $past(pwdata[CTRL_EN_BIT]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable not stored");

  property p_mute_zero;
    pop && (mute_ff || !en_ff) |=> out_frame.side == '0;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("muted sample leaked");

  property p_src_pick;
    pop && en_ff && !mute_ff |=> out_frame.side == $past(head.rec[src_ff]);
  endproperty
  a_src_pick: assert property (p_src_pick) else $error("wrong source");

  property p_gain_map;
    wr && idx == IDX_LEVEL |-> ##2 gain_cdb == code_to_cdb($past(pwdata[4:0], 2));
  endproperty
  a_gain_map: assert property (p_gain_map) else $error("gain map wrong");

  property p_left_empty;
    pop && lmask_ff == 3'h0 |=> out_frame.left == '0;
  endproperty
  a_left_empty: assert property (p_left_empty) else $error("left mix not empty");

  property p_right_rst;
    $past(srst) |-> rmask_ff == RST_RMASK;
  endproperty
  a_right_rst: assert property (p_right_rst) else $error("right mask reset");

  property p_opp_gate;
    pop && lmask_ff == 3'h2 && !filt_on_ff[FILT_ON_L_BIT] |=> out_frame.left == '0;
  endproperty
  a_opp_gate: assert property (p_opp_gate) else $error("opposite not gated");

  property p_data_store;
    wr && idx == IDX_CDATA |=> cdata_ff == $past(pwdata[7:0]);
  endproperty
  a_data_store: assert property (p_data_store) else $error("data byte lost");

  property p_high_commit;
    idx_wr && new_index[0] |=> coeff_upd ##0
      coeff[$past(new_index[4:1])][15:8] == $past(cdata_ff);
  endproperty
  a_high_commit: assert property (p_high_commit) else $error("high byte lost");

  property p_low_hold;
    idx_wr && !new_index[0] |=> $stable(coeff) && !coeff_upd;
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("half word applied");

  // Bus answer shape: one-cycle ready, error only with ready
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held high");

  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");

  property p_index_store;
    idx_wr |=> cindex_ff == $past(new_index);
  endproperty
  a_index_store: assert property (p_index_store) else $error("index not stored");

  property p_right_gate;
    pop && rmask_ff == 3'h1 && !filt_on_ff[FILT_ON_R_BIT] |=> out_frame.right == '0;
  endproperty
  a_right_gate: assert property (p_right_gate) else $error("right opp not gated");

  property p_live_state;
    side_live == ($past(en_ff) && !$past(mute_ff));
  endproperty
  a_live_state: assert property (p_live_state) else $error("live flag wrong");

  // Commits are single pulses; writes are never back to back
  property p_upd_pulse;
    coeff_upd |=> !coeff_upd;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("commit pulse held");

  c_live_pop:   cover property (pop && en_ff && !mute_ff);
  c_commit:     cover property (idx_wr && !new_index[0] ##[1:20] idx_wr && new_index[0]);
  c_fifo_full:  cover property (!in_ready);
  c_slverr:     cover property (pslverr);
  c_right_opp:  cover property (pop && rmask_ff[0] && filt_on_ff[FILT_ON_R_BIT]);
endmodule : stp_sidetone_ctrl
`default_nettype wire

// ---- tb/test_stp_sidetone_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_stp_sidetone_ctrl import stp_pkg::*;;
  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic                              clk, srst, psel, penable, pwrite;  // Clock, reset, APB
  logic [11:0]                       paddr;                     // APB byte address
  logic [31:0]                       pwdata, prdata, rd;        // APB data, last read
  logic                              pready, pslverr, err;      // APB answer, last error
  logic                              in_valid, in_ready, out_valid, out_ready; // Stream
  stp_in_frame_t                     in_frame;                  // Frame in
  stp_out_frame_t                    out_frame;                 // Frame out
  logic                              side_live, coeff_upd, rdy_en; // Status, sink enable
  logic signed [15:0]                gain_cdb;                  // Gain export
  logic [NUM_COEFF-1:0][COEFF_W-1:0] coeff;                     // Active words
  logic [3:0]                        coeff_upd_idx;             // Last word slot
  logic                              en, mute;                  // Control shadow
  logic [1:0]                        src, fo;                   // Source, filter enables
  logic [2:0]                        lm, rm;                    // Stream masks
  logic [15:0]                       cm [16];                   // Coefficient model
  logic [51:0]                       expq [$];                  // Expected frames
  int                                n_mismatch, tests_run, seed; // Counters, seed
  logic [7:0] ridx [8] = '{IDX_CTRL, IDX_SRC, IDX_LEVEL, IDX_LMASK, IDX_RMASK, IDX_CDATA,
                           IDX_CINDEX, IDX_FILT_ON};            // Register indices
  logic [7:0] rval [8] = '{8'h40, 8'h00, 8'h1C, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00}; // Resets

  stp_sidetone_ctrl #(.ADDR_W(12), .DEPTH(FIFO_DEPTH)) dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_frame(in_frame), .out_valid(out_valid),
    .out_ready(out_ready), .out_frame(out_frame), .side_live(side_live),
    .gain_cdb(gain_cdb), .coeff(coeff), .coeff_upd(coeff_upd), .coeff_upd_idx(coeff_upd_idx));

  // Core clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) chk(1, 0);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic e, input logic [7:0] v);
    apb(1'b0, idx, 32'h0);
    chk({err, rd}, {e, 24'h0, v});
  endtask : rdc

  // Expected mix of one frame under the shadow settings
  function automatic logic [51:0] mix(input stp_in_frame_t f);
    logic [15:0] s;
    logic [17:0] l, r;
    s = (en && !mute) ? f.rec[src] : 16'h0000;
    l = (lm[0] ? 18'(f.filt_l) : 18'h0) + ((lm[1] && fo[0]) ? 18'(f.filt_r) : 18'h0);
    l = l + (lm[2] ? 18'(s) : 18'h0);
    r = ((rm[0] && fo[1]) ? 18'(f.filt_l) : 18'h0) + (rm[1] ? 18'(f.filt_r) : 18'h0);
    r = r + (rm[2] ? 18'(s) : 18'h0);
    return {l, r, s};
  endfunction : mix

  // Offer one random frame until taken or refused
  task automatic push(output bit ok);
    int n;
    stp_in_frame_t f;
    f = {$random(seed), $random(seed), $random(seed)};
    in_valid <= 1'b1;
    in_frame <= f;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (in_ready !== 1'b1 && n < 200);
    ok = (in_ready === 1'b1);
    if (ok) expq.push_back(mix(f));
  endtask : push

  // Send n frames, then drain everything
  task automatic batch(input int n);
    bit ok;
    for (int i = 0; i < n; i++) begin
      push(ok);
      chk(ok, 1);
    end
    in_valid <= 1'b0;
    for (int i = 0; i < 600 && expq.size() != 0; i++) @(posedge clk);
    chk(expq.size(), 0);
  endtask : batch

  // ------------------------------------------------------------
  // Sink with random stalls, compares every frame
  // ------------------------------------------------------------
  always @(posedge clk) begin
    out_ready <= rdy_en && ($random(seed) % 2 != 0);
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (expq.size() == 0) chk(1, 0);
      else chk(out_frame, expq.pop_front());
    end
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    bit ok;
    int cnt;
    logic [3:0] w;
    logic [7:0] lo, hi;
    seed = 32'hDA41D95E;
    {srst, psel, penable, pwrite, in_valid, rdy_en} = 6'h21;
    {paddr, pwdata, in_frame} = '0;
    {en, mute, src, lm, rm, fo} = {1'b0, 1'b1, 2'h0, 3'h1, 3'h2, 2'h0};
    for (int i = 0; i < 16; i++) cm[i] = 16'h0000;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({side_live, gain_cdb}, 17'h0);
    for (int i = 0; i < 8; i++) rdc(ridx[i], 1'b0, rval[i]);
    rdc(8'hE7, 1'b1, 8'h00);
    batch(20);
    rdy_en = 1'b0;
    repeat (3) @(posedge clk);
    ok = 1'b1;
    cnt = 0;
    while (ok && cnt < 40) begin
      push(ok);
      if (ok) cnt++;
    end
    in_valid <= 1'b0;
    chk({in_ready, cnt >= FIFO_DEPTH && cnt <= FIFO_DEPTH + 2}, 2'b01);
    rdy_en = 1'b1;
    batch(0);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CTRL, {24'h0, 2'(c), 6'h0});
      @(posedge clk);
      chk(side_live, c == 2);
    end
    for (int c = 0; c < 32; c++) begin
      wr(IDX_LEVEL, 32'(c));
      @(posedge clk);
      chk({48'h0, gain_cdb}, {48'h0, 16'(-4200 + 150 * c)});
    end
    for (int k = 0; k < 8; k++) begin
      {en, mute, src, lm, rm, fo} = 12'($random(seed));
      wr(IDX_CTRL, {24'h0, en, mute, 6'h0});
      wr(IDX_SRC, 32'(src));
      wr(IDX_LMASK, 32'(lm));
      wr(IDX_RMASK, 32'(rm));
      wr(IDX_FILT_ON, 32'(fo));
      rdc(IDX_SRC, 1'b0, 8'(src));
      batch(12);
    end
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($random(seed));
      {lo, hi} = 16'($random(seed));
      wr(IDX_CDATA, 32'(lo));
      rdc(IDX_CDATA, 1'b0, lo);
      wr(IDX_CINDEX, {27'h0, w, 1'b0});
      @(posedge clk);
      chk(coeff[w], cm[w]);
      wr(IDX_CDATA, 32'(hi));
      wr(IDX_CINDEX, {27'h0, w, 1'b1});
      cm[w] = {hi, lo};
      chk({coeff_upd, coeff_upd_idx, coeff[w]}, {1'b1, w, cm[w]});
    end
    print_verdict();
  end
endmodule : test_stp_sidetone_ctrl
`default_nettype wire
